/* rtl/scc_system_clock_control.v */
// Summary of operation
// [R1] Source fuse picks external, 8 MHz or 32 kHz
// [R2] Fuse bit one means unprogrammed
// [R3] Source fuses readable, never writable
// [R4] Wake delay timed on selected source
// [R5] Reset adds delay timed by slow oscillator
// [R6] Start-up-time fuse sets delay length
// [R7] Provider holds reset over 2% steps
// [R8] Reset loads factory fast trim, writable
// [R9] Reset loads factory slow trim
// [R10] Fast oscillator keeps clocking watchdog, timeout
// [R11] Shipped fuses give 8 MHz over 8
// [R12] Same divider for all clocked domains
// [R13] Divider change is glitch free
// [R14] Ripple divider state not readable
// [R15] New rate active after two edges; the code switches only at the end of the current old period
// [R16] Output fuse drives clock onto pin
// [R17] No clock on pin during reset
// [R18] Pin carries divided clock
// [R19] Domain clocks gated by sleep controls
// [R20] Async interrupt detect survives halted clock
// [R21] Memory clock follows core clock
// [R22] ADC clock runs while core halted
// [R23] Codes 0..8 divide by powers to 256
// [R24] Reset divide one, eight if fuse programmed
// [R25] Signature opens four-cycle write window
// [R26] Wake 6 CK, reset 20 CK plus time
// [R27] Fuses sampled at reset, held after
`timescale 1ns/1ns
`include "scc_defines.vh"
module scc_system_clock_control #(
  parameter        [7:0]  FAST_TRIM_FACTORY = 8'h80,  // Arbitrary trim
  parameter        [7:0]  SLOW_TRIM_FACTORY = 8'h80,  // Arbitrary trim
  parameter integer       SHORT_SLOW_TICKS  =
    (`SCC_SHORT_US * `SCC_SLOW_HZ + 999999) / 1000000,
  parameter integer       LONG_SLOW_TICKS   =
    (`SCC_LONG_US * `SCC_SLOW_HZ + 999999) / 1000000
) (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        slowTick,        // One-cycle pulse per 32 kHz period
  input  wire        fastTick,        // One-cycle pulse per 8 MHz period
  input  wire        extTick,         // One-cycle pulse per external clock
  input  wire        wakeRequest,     // Pulse: leaving power-down
  input  wire [1:0]  clockSourceSelectFuse,
  input  wire [1:0]  startupTimeFuse,
  input  wire        divideByEightFuse,
  input  wire        clockOutputFuse,
  input  wire        sleepCore,       // Sleep gates core and peripheral
  input  wire        powerDownAdc,    // Power-reduction gate for ADC
  input  wire        asyncIrqPin,     // Level from async interrupt detector
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         coreEnable,      // Core may run
  output reg         periphEnable,
  output reg         nvmEnable,
  output reg         adcEnable,
  output reg         flashEnable,
  output reg         sysTick,         // Divided system clock strobe
  output reg         clockOutputPin,
  output reg         clockOutputEnable,
  output reg         timeoutClockFast, // Watchdog/timeout on fast osc
  output reg         irqWake          // Async interrupt seen
);
  // Start-up states. The sequencer holds the core off until the source
  // has been counted for the reset delay and then the slow delay; a
  // wake from power-down only runs a 6-clock source count, not the 20.
  // Binary codes keep the status word simple to decode in firmware.
  // Start-up states
  localparam [1:0] ST_RESET = 2'h0;
  localparam [1:0] ST_LONG  = 2'h1;
  localparam [1:0] ST_RUN   = 2'h2;
  localparam [1:0] ST_WAKE  = 2'h3;

  // Division factor as a count limit; reserved codes hold the old rate.
  // Shared by every domain so that all divided clocks stay in step;
  // codes above the top factor never reach this function.
  // Division factor as a count limit; reserved codes hold the old rate
  function [8:0] divLimit;
    input [3:0] code;
    begin
      divLimit = (9'h001 << code[3:0]) - 9'h001;
    end
  endfunction

  reg  [1:0]  state;        // Start-up sequencer
  reg  [1:0]  srcFuse;      // Latched fuses, held until reset
  reg  [1:0]  sutFuse;
  reg         outFuse;
  reg         fusesTaken;   // First cycle after release captures fuses
  reg  [15:0] waitCount;    // Start-up counter
  reg  [3:0]  prescaleSelect;
  reg  [3:0]  activeSelect; // Code the divider currently uses
  reg         pendingSwitch;
  reg  [8:0]  divCount;     // Divider count, not readable
  reg  [2:0]  windowCount;  // Open signature window
  reg  [7:0]  fastOscTrim;
  reg  [7:0]  slowOscTrim;
  reg  [7:0]  fastOscTempTrimA;
  reg  [7:0]  fastOscTempTrimB;
  reg         outPhase;     // Divided clock level
  wire        srcTick;
  wire        access;
  wire        commit;       // Edge where the master sees pready high
  wire [15:0] longTicks;

  // Selected source edge strobe; upper bit zero means external
  assign srcTick = ~srcFuse[1] ? extTick :                        // [R1]
                   (srcFuse == `SCC_SRC_FAST) ? fastTick : slowTick;
  assign access  = psel & penable & ~pready;
  // A write takes effect only where the master completes the transfer
  assign commit  = psel & penable & pready & pwrite;
  // Long part of the reset delay from start-up-time fuse
  assign longTicks = (sutFuse == `SCC_SUT_NONE) ? 16'h0000 :       // [R6]
                     (sutFuse == `SCC_SUT_SHORT) ?
                     SHORT_SLOW_TICKS[15:0] : LONG_SLOW_TICKS[15:0];

  // Fuse capture after reset release; values held until next reset.
  // Reset values match the shipped fuse pattern, so the outputs that
  // depend on them are quiet and sane in the cycle before capture.
  // A fuse that moves at run time has no effect until the next reset.
  // Fuse capture after reset release; values held until next reset
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fusesTaken <= 1'b0;
      srcFuse    <= `SCC_SRC_FAST;                               // [R11]
      sutFuse    <= 2'h3;
      outFuse    <= 1'b1;
    end else if (!fusesTaken) begin
      fusesTaken <= 1'b1;                                        // [R27]
      srcFuse    <= clockSourceSelectFuse;
      sutFuse    <= startupTimeFuse;
      outFuse    <= clockOutputFuse;
    end
  end

  // Start-up sequencer: 20 source clocks, slow delay, wake 6 clocks.
  // Counting waits for the fuse capture so that the source strobe in
  // use is the latched one; the long delay always runs on the slow
  // oscillator whatever the source. A wake request outside the run
  // state is ignored, since the core is not running then anyway.
  // Start-up sequencer: 20 source clocks, slow delay, wake 6 clocks
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state     <= ST_RESET;
      waitCount <= 16'h0000;
    end else begin
      case (state)
        ST_RESET: begin
          if (fusesTaken && srcTick) begin
            if (waitCount == {8'h00, `SCC_RESET_CK} - 16'h0001) begin // [R26]
              state     <= ST_LONG;
              waitCount <= 16'h0000;
            end else begin
              waitCount <= waitCount + 16'h0001;
            end
          end
        end
        ST_LONG: begin
          // Slow oscillator times the supply settling delay
          if (waitCount >= longTicks) begin                       // [R5]
            state <= ST_RUN;
          end else if (slowTick) begin
            waitCount <= waitCount + 16'h0001;
          end
        end
        ST_RUN: begin
          if (wakeRequest) begin
            state     <= ST_WAKE;
            waitCount <= 16'h0000;
          end
        end
        ST_WAKE: begin
          // Wake delay counted on the chosen source only
          if (srcTick) begin                                      // [R4]
            if (waitCount == {8'h00, `SCC_WAKE_CK} - 16'h0001) begin
              state <= ST_RUN;
            end else begin
              waitCount <= waitCount + 16'h0001;
            end
          end
        end
        default: state <= ST_RESET;
      endcase
    end
  end

  // Ripple-style divider counting source edges; switch at period end.
  // Waiting for the end of the old period costs up to one old period
  // of latency, but no period is ever shorter than both the old and
  // the new one. The count itself is kept off the register map.
  // A code written twice before the switch simply updates the target.
  // Ripple-style divider counting source edges; switch at period end
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      divCount      <= 9'h000;
      activeSelect  <= `SCC_PS_DIV1;
      pendingSwitch <= 1'b0;
      sysTick       <= 1'b0;
      outPhase      <= 1'b0;
    end else begin
      sysTick <= 1'b0;
      if (prescaleSelect != activeSelect) begin
        pendingSwitch <= 1'b1;
      end
      if (srcTick) begin
        if (divCount >= divLimit(activeSelect)) begin
          divCount <= 9'h000;
          sysTick  <= 1'b1;                                       // [R12]
          outPhase <= ~outPhase;
          // Only change at a full old period: no short pulse
          if (pendingSwitch) begin                                // [R13]
            activeSelect  <= prescaleSelect;                      // [R15]
            pendingSwitch <= 1'b0;
          end
        end else begin
          divCount <= divCount + 9'h001;
        end
      end
    end
  end

  // Domain enables; ADC keeps its own gate.
  // Core, peripheral, memory and flash share one gate so that memory
  // never runs ahead of the core. The pin follows the divided phase
  // and is forced low and undriven while reset is held.
  // All enables are registered, so they lag the state by one edge.
  // Domain enables; ADC keeps its own gate
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      coreEnable        <= 1'b0;
      periphEnable      <= 1'b0;
      nvmEnable         <= 1'b0;
      adcEnable         <= 1'b0;
      flashEnable       <= 1'b0;
      clockOutputPin    <= 1'b0;
      clockOutputEnable <= 1'b0;                                  // [R17]
      timeoutClockFast  <= 1'b0;
      irqWake           <= 1'b0;
    end else begin
      coreEnable   <= (state == ST_RUN) & ~sleepCore;             // [R19]
      periphEnable <= (state == ST_RUN) & ~sleepCore;
      nvmEnable    <= (state == ST_RUN) & ~sleepCore;             // [R21]
      flashEnable  <= (state == ST_RUN) & ~sleepCore;
      adcEnable    <= (state == ST_RUN) & ~powerDownAdc;          // [R22]
      // Programmed fuse reads zero and overrides the pin
      clockOutputEnable <= ~outFuse & fusesTaken;                 // [R16] [R2]
      clockOutputPin    <= ~outFuse & outPhase;                   // [R18]
      timeoutClockFast  <= (srcFuse == `SCC_SRC_FAST);            // [R10]
      irqWake           <= asyncIrqPin;                           // [R20]
    end
  end

  // APB slave: one wait state. Read data and the error flag are set at
  // the access edge and stand with pready; a write lands only at the
  // edge where the master samples pready high, so an aborted transfer
  // changes nothing. The window keeps counting during the wait state.
  // APB slave: one wait state, writes land at the completing edge
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= 32'h00000000;
      windowCount      <= 3'h0;
      fastOscTrim      <= FAST_TRIM_FACTORY;                      // [R8]
      slowOscTrim      <= SLOW_TRIM_FACTORY;                      // [R9]
      fastOscTempTrimA <= 8'h00;
      fastOscTempTrimB <= 8'h00;
      prescaleSelect   <= `SCC_PS_DIV1;
    end else begin
      pready  <= access;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (windowCount != 3'h0) begin
        windowCount <= windowCount - 3'h1;
      end
      // Reset value follows the latched divide fuse once taken
      if (!fusesTaken) begin
        prescaleSelect <= divideByEightFuse ? `SCC_PS_DIV1 :       // [R24]
                                              `SCC_PS_DIV8;
      end
      // Decode only here, so the error flag stands with pready
      if (access && pwrite) begin
        case (paddr)
          `SCC_ADDR_PRESCALE: pslverr <= 1'b0;
          `SCC_ADDR_PROTECT:  pslverr <= 1'b0;
          `SCC_ADDR_FASTTRIM: pslverr <= 1'b0;
          `SCC_ADDR_SLOWTRIM: pslverr <= 1'b0;
          `SCC_ADDR_TEMPA:    pslverr <= 1'b0;
          `SCC_ADDR_TEMPB:    pslverr <= 1'b0;
          `SCC_ADDR_FUSES:    pslverr <= 1'b1;                   // [R3]
          `SCC_ADDR_STATUS:   pslverr <= 1'b1;
          default:            pslverr <= 1'b1;
        endcase
      end else if (access) begin
        case (paddr)
          // Divider count itself is never mapped
          `SCC_ADDR_PRESCALE: prdata <= {28'h0, prescaleSelect};   // [R14]
          `SCC_ADDR_PROTECT:  prdata <= {29'h0, windowCount};
          `SCC_ADDR_FASTTRIM: prdata <= {24'h0, fastOscTrim};
          `SCC_ADDR_SLOWTRIM: prdata <= {24'h0, slowOscTrim};
          `SCC_ADDR_TEMPA:    prdata <= {24'h0, fastOscTempTrimA};
          `SCC_ADDR_TEMPB:    prdata <= {24'h0, fastOscTempTrimB};
          `SCC_ADDR_FUSES:    prdata <= {26'h0, outFuse, sutFuse,
                                         1'b0, srcFuse};          // [R3]
          `SCC_ADDR_STATUS:   prdata <= {26'h0, pendingSwitch,
                                         activeSelect[3:0] == 4'h0,
                                         2'h0, state};
          default:            pslverr <= 1'b1;
        endcase
      end
      // Write lands at the edge where the master samples pready; the
      // window check sees the count as it stands at that edge
      if (commit) begin
        case (paddr)
          `SCC_ADDR_PRESCALE: begin
            // Only inside the window; reserved codes dropped
            if (windowCount != 3'h0 &&                           // [R25]
                pwdata[3:0] <= `SCC_PS_MAX) begin                // [R23]
              prescaleSelect <= pwdata[3:0];
              windowCount    <= 3'h0;
            end
          end
          `SCC_ADDR_PROTECT: begin
            // Signature opens a short window for one prescale write
            if (pwdata[7:0] == `SCC_SIGNATURE) begin
              windowCount <= `SCC_WINDOW_CYCLES;
            end
          end
          `SCC_ADDR_FASTTRIM: fastOscTrim      <= pwdata[7:0];
          `SCC_ADDR_SLOWTRIM: slowOscTrim      <= pwdata[7:0];
          `SCC_ADDR_TEMPA:    fastOscTempTrimA <= pwdata[7:0];
          `SCC_ADDR_TEMPB:    fastOscTempTrimB <= pwdata[7:0];
          // Fuse, status and unmapped words keep their values
          default:            prdata           <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* rtl/scc_defines.vh */
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH
// Register byte addresses
`define SCC_ADDR_PRESCALE   12'h000
`define SCC_ADDR_PROTECT    12'h004
`define SCC_ADDR_FASTTRIM   12'h008
`define SCC_ADDR_SLOWTRIM   12'h00C
`define SCC_ADDR_TEMPA      12'h010
`define SCC_ADDR_TEMPB      12'h014
`define SCC_ADDR_FUSES      12'h018
`define SCC_ADDR_STATUS     12'h01C
// Change-protect signature and its open window in bus clocks
`define SCC_SIGNATURE       8'hD8
`define SCC_WINDOW_CYCLES   3'h4
// Prescale codes
`define SCC_PS_DIV1         4'h0
`define SCC_PS_DIV8         4'h3
`define SCC_PS_MAX          4'h8
// Source select codes
`define SCC_SRC_FAST        2'h2
`define SCC_SRC_SLOW        2'h3
// Start-up counts in source clocks
`define SCC_WAKE_CK         8'h06
`define SCC_RESET_CK        8'h14
// Start-up-time fuse codes
`define SCC_SUT_NONE        2'h0
`define SCC_SUT_SHORT       2'h1
// Long delays in microseconds, slow oscillator rate in hertz
`define SCC_SHORT_US        4000
`define SCC_LONG_US         64000
`define SCC_SLOW_HZ         32768
`endif

/* testbench/scc_tick_source.sv */
`timescale 1ns/1ns
// Source clocks, each seen as a one-cycle strobe on the system clock
module scc_tick_source #(
  parameter integer FAST_PER = 4,  // Cycles per fast oscillator edge
  parameter integer EXT_PER  = 6,  // Cycles per external clock edge
  parameter integer SLOW_PER = 50  // Cycles per slow oscillator edge
) (
  input  wire clk_sys,
  output reg  fastTick = 1'b0,
  output reg  extTick  = 1'b0,
  output reg  slowTick = 1'b0
);
  integer cnt = 0;  // Free-running cycle count
  // Periods never step, so the core needs no reset hold for a change
  always @(posedge clk_sys) begin
    cnt      <= cnt + 1;
    fastTick <= (cnt % FAST_PER) == 0;
    extTick  <= (cnt % EXT_PER) == 0;
    slowTick <= (cnt % SLOW_PER) == 0;
  end
endmodule

/* testbench/scc_checker_sva.sv */
`timescale 1ns/1ns
`include "scc_defines.vh"
// Gating, pin and bus relations at the controller ports
module scc_checker (
  input wire        clk_sys,
  input wire        reset_n,
  input wire [1:0]  clockSourceSelectFuse,
  input wire        clockOutputFuse,
  input wire        sleepCore,
  input wire        powerDownAdc,
  input wire        asyncIrqPin,
  input wire        wakeRequest,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire        coreEnable,
  input wire        periphEnable,
  input wire        nvmEnable,
  input wire        adcEnable,
  input wire        flashEnable,
  input wire        clockOutputPin,
  input wire        clockOutputEnable,
  input wire        timeoutClockFast,
  input wire        irqWake
);
  // One domain; all checks quiet while reset is held
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  nvm_follow_a:
    assert property (nvmEnable == coreEnable) else $error("nvm clock off");
  domain_same_a:
    assert property (periphEnable == coreEnable && flashEnable == coreEnable)
    else $error("domain enables differ");
  sleep_gate_a:
    assert property (sleepCore |=> !coreEnable) else $error("core not gated");
  adc_keeps_a:
    assert property (sleepCore && !powerDownAdc && adcEnable && !wakeRequest
      |=> adcEnable) else $error("adc clock stopped in sleep");
  pin_reset_a:
    assert property ($rose(reset_n) |-> !clockOutputPin && !clockOutputEnable)
    else $error("clock pin active in reset");
  pin_fuse_a:
    assert property ($past(reset_n, 2) |-> clockOutputEnable == !clockOutputFuse)
    else $error("clock pin enable wrong");
  timeout_fast_a:
    assert property ($past(reset_n, 2) |->
      timeoutClockFast == (clockSourceSelectFuse == `SCC_SRC_FAST))
    else $error("timeout clock wrong");
  irq_async_a:
    assert property (asyncIrqPin |=> irqWake) else $error("irq not seen");
  fuse_wr_err_a:
    assert property (psel && penable && pready && pwrite &&
      paddr == `SCC_ADDR_FUSES |-> pslverr) else $error("fuse write taken");
  cover property (wakeRequest);
  cover property (psel && penable && pready && pwrite);
  cover property (sleepCore && adcEnable);
endmodule
bind scc_system_clock_control scc_checker u_scc_checker (
  .clk_sys, .reset_n, .clockSourceSelectFuse, .clockOutputFuse, .sleepCore,
  .powerDownAdc, .asyncIrqPin, .wakeRequest, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .coreEnable, .periphEnable, .nvmEnable,
  .adcEnable, .flashEnable, .clockOutputPin, .clockOutputEnable,
  .timeoutClockFast, .irqWake);

/* testbench/test_system_clock_control.sv */
`timescale 1ns/1ns
`include "scc_defines.vh"
module test_system_clock_control;
  logic        clk_sys, reset_n, wakeRequest, divideByEightFuse, rerr;
  logic        clockOutputFuse, sleepCore, powerDownAdc, asyncIrqPin;
  logic        psel, penable, pwrite;
  logic [1:0]  clockSourceSelectFuse, startupTimeFuse, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat, p, pc, mn;
  wire         slowTick, fastTick, extTick, pready, pslverr, sysTick;
  wire         coreEnable, periphEnable, nvmEnable, adcEnable, flashEnable;
  wire         clockOutputPin, clockOutputEnable, timeoutClockFast, irqWake;
  wire  [31:0] prdata;
  integer      errors = 0, comparisons = 0, nSrc, nSlow, c, e, prev;
  scc_tick_source u_scc_tick_source (.clk_sys, .fastTick, .extTick,
    .slowTick);
  // Short slow-tick counts keep the long start-up delays brief
  scc_system_clock_control #(.SHORT_SLOW_TICKS(2), .LONG_SLOW_TICKS(4))
    u_scc_system_clock_control (.clk_sys, .reset_n, .slowTick, .fastTick,
    .extTick, .wakeRequest, .clockSourceSelectFuse, .startupTimeFuse,
    .divideByEightFuse, .clockOutputFuse, .sleepCore, .powerDownAdc,
    .asyncIrqPin, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .coreEnable, .periphEnable, .nvmEnable, .adcEnable,
    .flashEnable, .sysTick, .clockOutputPin, .clockOutputEnable,
    .timeoutClockFast, .irqWake);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("[ERR] %0t wait limit reached", $time);
    end_of_test();
  endtask
  // One transfer; hold keeps select up so a chained setup follows at once
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic hold);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rdat = prdata;
    rerr = pslverr;
    penable <= 1'b0;
    if (!hold) begin
      psel <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0);
    check(rdat, x);
  endtask
  // Count selected-source and slow strobes until the core is released
  task automatic wait_core;
    integer n;
    n = 0;
    nSrc = 0;
    nSlow = 0;
    while (coreEnable !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      nSrc += !clockSourceSelectFuse[1] ? extTick :
              clockSourceSelectFuse[0] ? slowTick : fastTick;
      nSlow += slowTick;
      if (n > 3000) hang();
    end
  endtask
  task automatic boot(input logic [1:0] f, input logic [1:0] t,
                      input logic d, input logic o);
    reset_n <= 1'b0;
    clockSourceSelectFuse <= f;
    startupTimeFuse <= t;
    divideByEightFuse <= d;
    clockOutputFuse <= o;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_core();
  endtask
  // Four divided periods: last length, shortest full one, pin changes
  task automatic period;
    integer k;
    logic   last;
    mn = 32'hFFFFFFFF;
    for (k = 0; k < 4; k++) begin
      p = 0;
      pc = 0;
      last = clockOutputPin;
      do begin
        @(posedge clk_sys);
        p++;
        pc += (clockOutputPin !== last);
        last = clockOutputPin;
      end while (sysTick !== 1'b1 && p < 3000);
      if (p >= 3000) hang();
      if (k > 0 && p < mn) mn = p;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {wakeRequest, sleepCore, powerDownAdc, asyncIrqPin} = 4'h0;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    boot(`SCC_SRC_FAST, 2'h0, 1'b0, 1'b0);
    check(nSrc >= 20 && nSrc <= 21, 1);
    rd(`SCC_ADDR_FUSES, 32'h02);
    rd(`SCC_ADDR_PRESCALE, `SCC_PS_DIV8);
    rd(`SCC_ADDR_FASTTRIM, 32'h80);
    rd(`SCC_ADDR_SLOWTRIM, 32'h80);
    apb(1'b1, `SCC_ADDR_FASTTRIM, 32'h5A, 1'b0);
    rd(`SCC_ADDR_FASTTRIM, 32'h5A);
    apb(1'b1, `SCC_ADDR_FUSES, 32'h0, 1'b0);
    check(rerr, 1);
    rd(`SCC_ADDR_FUSES, 32'h02);
    rd(12'h020, 32'h0);
    check(rerr, 1);
    check(timeoutClockFast, 1);
    check(clockOutputEnable, 1);
    apb(1'b1, `SCC_ADDR_PRESCALE, 32'h1, 1'b0);
    rd(`SCC_ADDR_PRESCALE, `SCC_PS_DIV8);
    apb(1'b1, `SCC_ADDR_PROTECT, `SCC_SIGNATURE, 1'b0);
    repeat (5) @(posedge clk_sys);
    apb(1'b1, `SCC_ADDR_PRESCALE, 32'h1, 1'b0);
    rd(`SCC_ADDR_PRESCALE, `SCC_PS_DIV8);
    $display("test registers done");
    prev = 3;
    for (c = 0; c < 10; c++) begin
      e = (c > 8) ? 8 : c;
      apb(1'b1, `SCC_ADDR_PROTECT, `SCC_SIGNATURE, 1'b1);
      apb(1'b1, `SCC_ADDR_PRESCALE, c, 1'b0);
      rd(`SCC_ADDR_PRESCALE, e);
      period();
      check(p, 32'd4 << e);
      check(pc, 1);
      check(mn >= (32'd4 << ((prev < e) ? prev : e)), 1);
      prev = e;
    end
    $display("test prescaler done");
    sleepCore <= 1'b1;
    asyncIrqPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check(coreEnable, 0);
    check(adcEnable, 1);
    check(irqWake, 1);
    powerDownAdc <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(adcEnable, 0);
    powerDownAdc <= 1'b0;
    wakeRequest <= 1'b1;
    @(posedge clk_sys);
    wakeRequest <= 1'b0;
    sleepCore <= 1'b0;
    wait_core();
    check(nSrc >= 5 && nSrc <= 7, 1);
    $display("test wake done");
    for (c = 0; c < 3; c++) begin
      s = (c == 2) ? `SCC_SRC_SLOW : c[1:0];
      boot(s, c[1:0] + 2'h1, 1'b1, 1'b1);
      check(nSrc >= 20 && nSlow >= ((c == 0) ? 2 : 4), 1);
      rd(`SCC_ADDR_FUSES, {26'h0, 1'b1, c[1:0] + 2'h1, 1'b0, s});
      rd(`SCC_ADDR_PRESCALE, `SCC_PS_DIV1);
      check(clockOutputEnable, 0);
    end
    $display("test sources done");
    end_of_test();
  end
endmodule
